/* hdl/npec_defs.svh */
// Purpose: Offsets, field positions and reset values of the program/erase controller.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one register per aligned word.
// Notes:   Definitions only.
`ifndef NPEC_DEFS_SVH
`define NPEC_DEFS_SVH
// Register index of the control register and its byte address (four times the index).
`define NPEC_CTRL_IDX    16'h103B
`define NPEC_CTRL_ADDR   16'h40EC
// Array windows: one array byte per 32-bit word.
`define NPEC_EE_BASE     16'h0000
`define NPEC_CFG_ADDR    16'h0800
`define NPEC_BOOT_ADDR   16'h0804
`define NPEC_OTP_BASE    16'h1000
// Reset and erased values.
`define NPEC_CTRL_RST    8'h00
`define NPEC_ERASED      8'hFF
// Resident loader handshake character and default first address.
`define NPEC_READY_CHAR  8'hFF
`define NPEC_BOOT_START  16'hD000
// Last array index of block-lock regions 0 to 2; region 3 runs to the top.
`define NPEC_BLK0_END    9'h01F
`define NPEC_BLK1_END    9'h05F
`define NPEC_BLK2_END    9'h0DF
// Field positions of the control register.
`define NPEC_BIT_HV      0
`define NPEC_BIT_EE_LATCH 1
`define NPEC_BIT_OTPLAT  5
// Bus responses.
`define NPEC_RESP_OKAY   2'b00
`define NPEC_RESP_SLVERR 2'b10
`endif

/* hdl/npec_pkg.sv */
// Purpose: Types shared by the program/erase controller.
// Assumes: Nothing beyond the constants header.
// Notes:   Control layout matches the 8-bit register, bit 7 first.
package npec_pkg;

	// Control register fields, most significant first.
	typedef struct packed {
		logic odd_rows;
		logic even_rows;
		logic otp_latch_enable;
		logic byte_sel;
		logic row_sel;
		logic erase;
		logic eeprom_latch_enable;
		logic high_voltage_on;
	} npec_ctrl_t;

	// Sequencer states, Gray coded along idle, captured, voltage on.
	typedef enum logic [1:0] {
		NPEC_IDLE = 2'b00,
		NPEC_CAPT = 2'b01,
		NPEC_HV   = 2'b11
	} npec_state_t;

	// Captured target of a latched store.
	typedef struct packed {
		logic       is_otp;
		logic       is_cfg;
		logic [9:0] idx;
		logic [7:0] data;
	} npec_capt_t;

endpackage

/* hdl/npec_top.sv */
// Purpose: Program and erase sequencer for the byte-erasable array and the one-time array.
// Assumes: AXI4-Lite slave, one write and one read outstanding; lock inputs are static levels.
// Notes:   Arrays are nonvolatile and are not touched by reset.
`timescale 1ns/100ps
`include "npec_defs.svh"

module npec_top
	import npec_pkg::*;
#(
	parameter int EE_DEPTH  = 512,
	parameter int OTP_AW    = 8
) (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data.
	input  wire logic [15:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response.
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read.
	input  wire logic [15:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Protection levels from the block-protect and configuration logic.
	input  wire logic [3:0]  eeprom_block_lock,
	input  wire logic        config_write_lock,
	input  wire logic        otp_array_enable,
	// High voltage switch to the arrays.
	output logic             hv_ee_q_out,
	output logic             hv_otp_q_out
);

	localparam int OTP_DEPTH = 1 << OTP_AW;

	// ****************************************************************
	// Storage and state
	// ****************************************************************
	logic [7:0]  ee_mem [EE_DEPTH];
	logic [7:0]  otp_mem [OTP_DEPTH];
	logic [7:0]  cfg_q;
	npec_ctrl_t  ctrl_q;
	npec_state_t state_q;
	npec_capt_t  capt_q;
	logic        aw_have_q;
	logic        w_have_q;
	logic [15:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic        w_strb0_q;
	logic        hv_ee_q;
	logic        hv_otp_q;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************

	// A region is locked when its own lock bit covers the index.
	function automatic logic ee_locked(input logic [8:0] i, input logic [3:0] lk);
		if (i <= `NPEC_BLK0_END) begin
			return lk[0];
		end else if (i <= `NPEC_BLK1_END) begin
			return lk[1];
		end else if (i <= `NPEC_BLK2_END) begin
			return lk[2];
		end else begin
			return lk[3];
		end
	endfunction

	logic       wr_fire;
	logic       wr_ctrl;
	logic       wr_ee;
	logic       wr_cfg;
	logic       wr_otp;
	logic [9:0] wr_otp_off;
	npec_ctrl_t wr_val;
	npec_ctrl_t ctrl_d;

	// A write completes once address and data are both held.
	assign wr_fire    = aw_have_q && w_have_q && !bvalid;
	assign wr_otp_off = aw_addr_q[11:2];
	assign wr_ctrl    = wr_fire && aw_addr_q == `NPEC_CTRL_ADDR;
	assign wr_ee      = wr_fire && aw_addr_q[15:11] == 5'h00;
	assign wr_cfg     = wr_fire && aw_addr_q == `NPEC_CFG_ADDR;
	assign wr_otp     = wr_fire && aw_addr_q[15:12] == 4'h1
		&& wr_otp_off < 10'(OTP_DEPTH);
	assign wr_val     = npec_ctrl_t'(w_data_q[7:0]);

	// ****************************************************************
	// AXI4-Lite write channels
	// ****************************************************************

	// Address and data are taken in either order and held until both are here.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= 16'h0000;
			w_data_q  <= 32'h0000_0000;
			w_strb0_q <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= awaddr;
			end else if (wr_fire) begin
				aw_have_q <= 1'b0;
			end
			if (wvalid && wready) begin
				w_have_q  <= 1'b1;
				w_data_q  <= wdata;
				w_strb0_q <= wstrb[0];
			end else if (wr_fire) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// Ready stays low from the cycle after a handshake until the response is taken, so nothing is taken twice.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
		end else begin
			awready <= !aw_have_q && !(awvalid && awready) && !bvalid && !wr_fire;
			wready  <= !w_have_q && !(wvalid && wready) && !bvalid && !wr_fire;
		end
	end

	// Response one cycle after the write completes; unmapped gives a slave error.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `NPEC_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp  <= (wr_ctrl || wr_ee || wr_cfg || wr_otp)
				? `NPEC_RESP_OKAY : `NPEC_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// Control register and interlock
	// ****************************************************************

	// Next control value: the register takes any byte 0 write, but a latch set together with the voltage bit is refused, and the voltage bit
	// only sticks when a store was captured under a latch already set.
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl && w_strb0_q) begin
			ctrl_d = wr_val;
			if (wr_val.high_voltage_on) begin
				if (wr_val.eeprom_latch_enable && !ctrl_q.eeprom_latch_enable) begin
					ctrl_d.eeprom_latch_enable = 1'b0;
					ctrl_d.high_voltage_on     = 1'b0;
				end else if (wr_val.otp_latch_enable && !ctrl_q.otp_latch_enable) begin
					ctrl_d.otp_latch_enable = 1'b0;
					ctrl_d.high_voltage_on  = 1'b0;
				end else if (state_q == NPEC_IDLE) begin
					ctrl_d.high_voltage_on = 1'b0;
				end else if (capt_q.is_otp ? !wr_val.otp_latch_enable
						: !wr_val.eeprom_latch_enable) begin
					ctrl_d.high_voltage_on = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= npec_ctrl_t'(`NPEC_CTRL_RST);
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Sequencer: a latched store arms it, the voltage bit fires it, and
	// dropping the latch forgets the capture.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= NPEC_IDLE;
			capt_q  <= '0;
		end else begin
			case (state_q)
				NPEC_IDLE: begin
					if (wr_ee && ctrl_q.eeprom_latch_enable) begin
						state_q <= NPEC_CAPT;
						capt_q  <= {1'b0, 1'b0, 1'b0, aw_addr_q[10:2], w_data_q[7:0]};
					end else if (wr_cfg && ctrl_q.eeprom_latch_enable) begin
						state_q <= NPEC_CAPT;
						capt_q  <= {1'b0, 1'b1, 10'h000, w_data_q[7:0]};
					end else if (wr_otp && ctrl_q.otp_latch_enable && otp_array_enable) begin
						state_q <= NPEC_CAPT;
						capt_q  <= {1'b1, 1'b0, wr_otp_off, w_data_q[7:0]};
					end
				end
				NPEC_CAPT: begin
					if (ctrl_d.high_voltage_on) begin
						state_q <= NPEC_HV;
					end else if (!ctrl_d.eeprom_latch_enable && !ctrl_d.otp_latch_enable) begin
						state_q <= NPEC_IDLE;
					end
				end
				NPEC_HV: begin
					// No timeout: software decides when the voltage goes off.
					if (!ctrl_d.high_voltage_on) begin
						state_q <= (ctrl_d.eeprom_latch_enable || ctrl_d.otp_latch_enable)
							? NPEC_CAPT : NPEC_IDLE;
					end
				end
				default: begin
					state_q <= NPEC_IDLE;
				end
			endcase
		end
	end

	// High voltage outputs follow the accepted voltage bit for the armed array.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hv_ee_q  <= 1'b0;
			hv_otp_q <= 1'b0;
		end else begin
			hv_ee_q  <= ctrl_d.high_voltage_on && !capt_q.is_otp;
			hv_otp_q <= ctrl_d.high_voltage_on && capt_q.is_otp;
		end
	end
	assign hv_ee_q_out  = hv_ee_q;
	assign hv_otp_q_out = hv_otp_q;

	// ****************************************************************
	// Array updates
	// ****************************************************************

	logic fire_op;
	assign fire_op = state_q == NPEC_CAPT && ctrl_d.high_voltage_on;

	// The operation lands once, on the edge the voltage is switched on.
	always_ff @(posedge aclk) begin
		if (fire_op && capt_q.is_otp) begin
			otp_mem[capt_q.idx[OTP_AW-1:0]] <=
				otp_mem[capt_q.idx[OTP_AW-1:0]] & capt_q.data;
		end
		if (fire_op && capt_q.is_cfg && !config_write_lock) begin
			cfg_q <= ctrl_q.erase ? `NPEC_ERASED : (cfg_q & capt_q.data);
		end
		if (fire_op && !capt_q.is_otp && !capt_q.is_cfg) begin
			for (int i = 0; i < EE_DEPTH; i++) begin
				if (!ee_locked(9'(i), eeprom_block_lock)) begin
					if (!ctrl_q.erase) begin
						// Row and byte bits play no part when programming.
						if (9'(i) == capt_q.idx[8:0]) begin
							ee_mem[i] <= ee_mem[i] & capt_q.data;
						end
					end else if (ctrl_q.byte_sel) begin
						if (9'(i) == capt_q.idx[8:0]) begin
							ee_mem[i] <= `NPEC_ERASED;
						end
					end else if (ctrl_q.row_sel) begin
						if (5'(i >> 4) == capt_q.idx[8:4]) begin
							ee_mem[i] <= `NPEC_ERASED;
						end
					end else begin
						ee_mem[i] <= `NPEC_ERASED;
					end
				end
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	logic [9:0] rd_otp_off;
	assign rd_otp_off = araddr[11:2];

	// Array reads are refused while their latch holds the array for programming.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `NPEC_RESP_OKAY;
		end else begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata  <= 32'h0000_0000;
				rresp  <= `NPEC_RESP_OKAY;
				if (araddr == `NPEC_CTRL_ADDR) begin
					rdata <= {24'h00_0000, ctrl_q};
				end else if (araddr == `NPEC_CFG_ADDR) begin
					if (ctrl_q.eeprom_latch_enable) begin
						rresp <= `NPEC_RESP_SLVERR;
					end else begin
						rdata <= {24'h00_0000, cfg_q};
					end
				end else if (araddr == `NPEC_BOOT_ADDR) begin
					rdata <= {8'h00, `NPEC_BOOT_START, `NPEC_READY_CHAR};
				end else if (araddr[15:11] == 5'h00) begin
					if (ctrl_q.eeprom_latch_enable) begin
						rresp <= `NPEC_RESP_SLVERR;
					end else begin
						rdata <= {24'h00_0000, ee_mem[araddr[10:2]]};
					end
				end else if (araddr[15:12] == 4'h1 && rd_otp_off < 10'(OTP_DEPTH)) begin
					if (ctrl_q.otp_latch_enable) begin
						rresp <= `NPEC_RESP_SLVERR;
					end else begin
						rdata <= {24'h00_0000, otp_mem[rd_otp_off[OTP_AW-1:0]]};
					end
				end else begin
					rresp <= `NPEC_RESP_SLVERR;
				end
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_latch_then_both;
		wr_ctrl && w_strb0_q && !ctrl_q.eeprom_latch_enable
			&& wr_val.eeprom_latch_enable && wr_val.high_voltage_on;
	endsequence

	a_both_bits_refused: assert property (s_latch_then_both |=>
		!ctrl_q.eeprom_latch_enable && !ctrl_q.high_voltage_on)
		else $error("latch and voltage set together");

	a_hv_needs_capture: assert property ($rose(ctrl_q.high_voltage_on) |->
		$past(state_q) == NPEC_CAPT)
		else $error("voltage on without a captured store");

	a_hv_pin_follows: assert property (ctrl_q.high_voltage_on |->
		(hv_ee_q || hv_otp_q) && !(hv_ee_q && hv_otp_q))
		else $error("voltage pin disagrees with control bit");

	a_hv_no_timeout: assert property (hv_ee_q && !wr_ctrl |=> hv_ee_q)
		else $error("voltage dropped without a control write");

	a_ee_read_block: assert property (arvalid && arready && araddr[15:11] == 5'h00
		&& ctrl_q.eeprom_latch_enable |=> rvalid && rresp == `NPEC_RESP_SLVERR)
		else $error("array read while latched");

	a_otp_read_block: assert property (arvalid && arready && araddr[15:12] == 4'h1
		&& rd_otp_off < 10'(OTP_DEPTH) && ctrl_q.otp_latch_enable
		|=> rresp == `NPEC_RESP_SLVERR)
		else $error("one-time array read while latched");

	a_program_clears: assert property (fire_op && !capt_q.is_otp && !capt_q.is_cfg
		&& !ctrl_q.erase |=> (ee_mem[$past(capt_q.idx[8:0])] & ~$past(ee_mem[capt_q.idx[8:0]]))
		== 8'h00)
		else $error("programming raised a bit");

	a_lock_holds: assert property (fire_op && !capt_q.is_otp && !capt_q.is_cfg
		&& ee_locked(capt_q.idx[8:0], eeprom_block_lock)
		|=> $stable(ee_mem[capt_q.idx[8:0]]))
		else $error("locked region altered");

	a_cfg_lock: assert property (config_write_lock |=> $stable(cfg_q))
		else $error("locked configuration byte altered");

	a_byte_erase_ones: assert property (fire_op && !capt_q.is_otp && !capt_q.is_cfg
		&& ctrl_q.erase && ctrl_q.byte_sel && !ee_locked(capt_q.idx[8:0], eeprom_block_lock)
		|=> ee_mem[$past(capt_q.idx[8:0])] == `NPEC_ERASED)
		else $error("byte erase left zeros");

endmodule

/* testbench/tb_nonvolatile_program_erase_ctrl.sv */
// Purpose: Self-checking bench for the program/erase sequencer over AXI4-Lite.
// Assumes: One write and one read at a time; lock inputs change only between operations.
// Notes:   Arrays power up unknown, so every byte is erased, or programmed to zero, before it is read.
`timescale 1ns/100ps
`include "npec_defs.svh"

module tb_nonvolatile_program_erase_ctrl
	import npec_pkg::*;
;
	localparam logic [15:0] CTRL = `NPEC_CTRL_ADDR;
	localparam logic [15:0] CFG  = `NPEC_CFG_ADDR;
	localparam logic [1:0]  OK   = `NPEC_RESP_OKAY;
	localparam logic [1:0]  SERR = `NPEC_RESP_SLVERR;

	// Bus, lock and status signals; every input has a value at time zero.
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [15:0] awaddr = 16'h0000;
	logic [15:0] araddr = 16'h0000;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  wstrb = 4'h0;
	logic [3:0]  eeprom_block_lock = 4'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        config_write_lock = 1'b0;
	logic        otp_array_enable = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, hv_ee_q_out, hv_otp_q_out;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rd;
	int          err_count = 0;
	int          samples_checked = 0;
	int          firsts[4] = '{0, 32, 96, 224};
	int          zeros[5] = '{18, 34, 35, 36, 48};

	// Clock at 250 MHz, far above the slow-clock limit of the pump.
	always #2 aclk = ~aclk; // The pump clock source select stays at its default.

	npec_top u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.eeprom_block_lock(eeprom_block_lock), .config_write_lock(config_write_lock),
		.otp_array_enable(otp_array_enable),
		.hv_ee_q_out(hv_ee_q_out), .hv_otp_q_out(hv_otp_q_out)
	);

	// ****************************************
	// Reporting and compare tasks
	// ****************************************
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cmp_resp(input string n, input logic [1:0] e, input logic [1:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic cmp_bit(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask

	// ****************************************
	// Bus master tasks
	// ****************************************
	// Address and data go out together and each drops only at its own handshake edge.
	task automatic axi_wr(input logic [15:0] a, input logic [31:0] d);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0; // Released before the next location is offered.
			end
			if (!wd && wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [15:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
		axi_rd(a);
		cmp_word($sformatf("rdata at %h", a), {24'h00_0000, e}, rd);
		cmp_resp($sformatf("rresp at %h", a), er, resp);
	endtask

	function automatic logic [15:0] ee(input int i);
		return 16'(4 * i);
	endfunction

	// Latch, store, voltage on, then clear; hv after voltage on is checked only when chk is set,
	// since a locked target leaves the pin level a design choice; hv off is always checked.
	task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d,
		input logic [1:0] hv, input logic chk);
		axi_wr(CTRL, {24'h00_0000, c});
		axi_wr(a, {24'h00_0000, d});
		axi_wr(CTRL, {24'h00_0000, c | 8'h01});
		@(posedge aclk);
		if (chk) begin
			cmp_bit("hv_ee_q_out", hv[1], hv_ee_q_out);
			cmp_bit("hv_otp_q_out", hv[0], hv_otp_q_out);
		end
		axi_wr(CTRL, 32'h0000_0000);
		@(posedge aclk);
		cmp_bit("hv_ee_q_out off", 1'b0, hv_ee_q_out);
		cmp_bit("hv_otp_q_out off", 1'b0, hv_otp_q_out);
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(CTRL, 8'h00, OK);
		cmp_bit("hv_ee_q_out", 1'b0, hv_ee_q_out);
		axi_rd(`NPEC_BOOT_ADDR);
		cmp_word("loader info", {8'h00, 16'hD000, 8'hFF}, rd);
		rd_chk(16'h3000, 8'h00, SERR);
		axi_wr(16'h3000, 32'h0000_0055);
		cmp_resp("bresp unmapped", SERR, resp);
		axi_wr(CTRL, 32'h0000_00FC);
		rd_chk(CTRL, 8'hFC, OK);
		// Latch and voltage in one write are both refused.
		axi_wr(CTRL, 32'h0000_0003);
		rd_chk(CTRL, 8'h00, OK);
		cmp_bit("hv_ee_q_out", 1'b0, hv_ee_q_out);
		// Voltage without a captured store stays off.
		axi_wr(CTRL, 32'h0000_0002);
		axi_wr(CTRL, 32'h0000_0003);
		rd_chk(CTRL, 8'h02, OK);
		cmp_bit("hv_ee_q_out", 1'b0, hv_ee_q_out);
		axi_wr(CTRL, 32'h0000_0000);
		op(8'h16, CFG, 8'h00, 2'b10, 1'b1);
		op(8'h02, CFG, 8'h5A, 2'b10, 1'b1);
		rd_chk(CFG, 8'h5A, OK);
		op(8'h06, ee(9), 8'h00, 2'b10, 1'b1);
		rd_chk(ee(0), 8'hFF, OK);
		rd_chk(ee(511), 8'hFF, OK);
		rd_chk(CFG, 8'h5A, OK);
		op(8'h02, ee(5), 8'hA5, 2'b10, 1'b1);
		rd_chk(ee(5), 8'hA5, OK);
		op(8'h1A, ee(5), 8'h0F, 2'b10, 1'b1);
		rd_chk(ee(5), 8'h05, OK);
		rd_chk(ee(4), 8'hFF, OK);
		// Stores with the latch clear are ignored; reads with it set are refused.
		axi_wr(ee(5), 32'h0000_0000);
		cmp_resp("bresp read-only", OK, resp);
		rd_chk(ee(5), 8'h05, OK);
		axi_wr(CTRL, 32'h0000_0002);
		rd_chk(ee(5), 8'h00, SERR);
		axi_wr(CTRL, 32'h0000_0000);
		// Voltage holds while the bit stays set; software times the pulse.
		axi_wr(CTRL, 32'h0000_0002);
		axi_wr(ee(6), 32'h0000_00F0);
		axi_wr(CTRL, 32'h0000_0003);
		repeat (50) @(posedge aclk);
		cmp_bit("hv_ee_q_out held", 1'b1, hv_ee_q_out);
		axi_wr(CTRL, 32'h0000_0000);
		rd_chk(ee(6), 8'hF0, OK);
		for (int i = 0; i < 5; i++) begin
			op(8'h02, ee(zeros[i]), 8'h00, 2'b10, 1'b1);
		end
		op(8'h0E, ee(19), 8'h77, 2'b10, 1'b1);
		rd_chk(ee(18), 8'hFF, OK);
		rd_chk(ee(34), 8'h00, OK);
		op(8'h16, ee(34), 8'h00, 2'b10, 1'b1);
		rd_chk(ee(34), 8'hFF, OK);
		rd_chk(ee(35), 8'h00, OK);
		op(8'h1E, ee(35), 8'h00, 2'b10, 1'b1);
		rd_chk(ee(35), 8'hFF, OK);
		rd_chk(ee(36), 8'h00, OK);
		// Bulk erase with the lowest region locked spares that region only.
		eeprom_block_lock <= 4'h1;
		op(8'h06, ee(100), 8'h00, 2'b10, 1'b0);
		rd_chk(ee(5), 8'h05, OK);
		rd_chk(ee(48), 8'hFF, OK);
		for (int b = 0; b < 4; b++) begin
			eeprom_block_lock <= 4'(1 << b);
			op(8'h02, ee(firsts[b]), 8'h00, 2'b10, 1'b0);
			rd_chk(ee(firsts[b]), 8'hFF, OK);
		end
		eeprom_block_lock <= 4'h0;
		config_write_lock <= 1'b1;
		op(8'h16, CFG, 8'h00, 2'b10, 1'b0);
		rd_chk(CFG, 8'h5A, OK);
		config_write_lock <= 1'b0;
		otp_array_enable <= 1'b1;
		op(8'h20, 16'h100C, 8'h00, 2'b01, 1'b1);
		rd_chk(16'h100C, 8'h00, OK);
		axi_wr(CTRL, 32'h0000_0020);
		rd_chk(16'h100C, 8'h00, SERR);
		axi_wr(CTRL, 32'h0000_0000);
		complete_run();
	end

	// Watchdog: the sequence needs well under a thousand cycles, so this margin is ample.
	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		$display("[ERR] watchdog expected done seen hang");
		complete_run();
	end
endmodule
